//--- phy_irq_pkg.sv
// Constants, register map and carrier types for the PHY interrupt and
// special-control block.
// Assumes word-wide AHB-Lite access; each 16-bit register sits in the low
// half of one aligned word at byte address index*4.
package phy_irq_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	// Word indices; the byte address is four times the index
	localparam logic [7:0] IDX_SPECIAL = 8'h11;
	localparam logic [7:0] IDX_EVENT = 8'h12;
	localparam logic [7:0] IDX_AUX = 8'h20;
	localparam logic [15:0] SPECIAL_RESET = 16'h010b;
	localparam logic [7:0] EVENT_EN_RESET = 8'h00;
	// Bits 15:7 and 3:0 are writable, 6:4 read as zero
	localparam logic [15:0] SPECIAL_WR_MASK = 16'hff8f;

	// ------------------------------------------------------------------
	// Special-control field positions
	// ------------------------------------------------------------------
	localparam int SC_CLK_DIS = 15;
	localparam int SC_PS_OVR = 14;
	localparam int SC_PS_HI = 13;
	localparam int SC_PS_LO = 12;
	localparam int SC_SGMII_RST = 11;
	localparam int SC_ISO_ZERO = 10;
	localparam int SC_FIFO_HI = 9;
	localparam int SC_FIFO_LO = 8;
	localparam int SC_INT_POL = 3;
	localparam int SC_FORCE = 2;
	localparam int SC_GEN = 1;
	localparam int SC_PIN_OUT = 0;
	localparam logic [1:0] PS_IEEE = 2'h1;
	localparam logic [4:0] PHY_ADDR_ZERO = 5'h00;

	// RMII transmit FIFO depth in nibbles per field code
	localparam logic [3:0] FIFO_DEPTH_0 = 4'h4;
	localparam logic [3:0] FIFO_DEPTH_1 = 4'h5;
	localparam logic [3:0] FIFO_DEPTH_2 = 4'h6;
	localparam logic [3:0] FIFO_DEPTH_3 = 4'h8;

	// ------------------------------------------------------------------
	// Event and auxiliary bit positions
	// ------------------------------------------------------------------
	// Index within the pending byte; status bit is index + 8
	localparam int EV_LINK_QUAL = 7;
	localparam int EV_ENERGY = 6;
	localparam int EV_LINK = 5;
	localparam int EV_WOL = 4;
	localparam int EV_ESD = 3;
	localparam int EV_TRAIN = 2;
	localparam int EV_FC_HALF = 1;
	localparam int EV_RX_HALF = 0;
	localparam int AUX_RISE_ONLY = 0;
	localparam int AUX_PIN_FLAG = 1;
	localparam int AUX_PD_PIN = 2;
	localparam int AUX_IRQ_ACTIVE = 3;

	// AHB-Lite encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [21:0] HADDR_HI_ZERO = 22'h000000;

	// ------------------------------------------------------------------
	// Carrier and state types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic link_qual_good;
		logic link_up;
		logic energy_det;
		logic wol_rx;
		logic esd_det;
		logic training_complete_event;
		logic false_carrier_half;
		logic rx_err_half;
	} event_in_s;

	typedef struct packed {
		logic clk_out_en;
		logic ps_down;
		logic pll_down;
		logic isolate_mac;
		logic sgmii_reset;
		logic [3:0] fifo_depth;
	} power_ctrl_s;

	typedef struct packed {
		logic primed;
		logic lq_bad;
		logic link_up;
		logic energy;
		logic fc_half;
		logic rx_half;
		logic pd_meta;
		logic pd_sync;
	} cap_state_s;

	typedef struct packed {
		logic [15:0] sc;
		logic [7:0] ev_en;
		logic [7:0] pend;
		logic rise_only;
		logic pin_flag;
		logic irq_level;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [15:0] rdata;
	} ctl_s;

endpackage

//--- event_capture.sv
// Edge detection of the PHY event sources and pin synchroniser.
// Assumes the event sources run on hclk; the shared pin is asynchronous.
`timescale 1ns/1ps

module event_capture (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Event sources and options
	input phy_irq_pkg::event_in_s ev_in,
	input wire logic rise_only,
	// Shared pin in input mode
	input wire logic pd_pin_raw,
	// Results
	output logic [7:0] ev_pulse,
	output logic pd_pin_sync
);

	phy_irq_pkg::cap_state_s s_ff;
	phy_irq_pkg::cap_state_s nxt_s;
	logic lq_bad;
	logic en_rise;
	logic en_fall;

	// ------------------------------------------------------------------
	// Event pulses
	// ------------------------------------------------------------------
	// No edges before the first sample, so reset is not taken as a change
	always_comb begin
		lq_bad = ev_in.link_up & ~ev_in.link_qual_good;
		en_rise = ev_in.energy_det & ~s_ff.energy;
		en_fall = ~ev_in.energy_det & s_ff.energy;
		ev_pulse = 8'h00;
		ev_pulse[phy_irq_pkg::EV_LINK_QUAL] = s_ff.primed & lq_bad &
			~s_ff.lq_bad;
		ev_pulse[phy_irq_pkg::EV_ENERGY] = s_ff.primed &
			(en_rise | (en_fall & ~rise_only));
		ev_pulse[phy_irq_pkg::EV_LINK] = s_ff.primed &
			(ev_in.link_up ^ s_ff.link_up);
		ev_pulse[phy_irq_pkg::EV_WOL] = ev_in.wol_rx;
		ev_pulse[phy_irq_pkg::EV_ESD] = ev_in.esd_det;
		ev_pulse[phy_irq_pkg::EV_TRAIN] =
			ev_in.training_complete_event;
		ev_pulse[phy_irq_pkg::EV_FC_HALF] = s_ff.primed &
			ev_in.false_carrier_half & ~s_ff.fc_half;
		ev_pulse[phy_irq_pkg::EV_RX_HALF] = s_ff.primed &
			ev_in.rx_err_half & ~s_ff.rx_half;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// First sync stage feeds only the second
	always_comb begin
		nxt_s = s_ff;
		nxt_s.primed = 1'b1;
		nxt_s.lq_bad = lq_bad;
		nxt_s.link_up = ev_in.link_up;
		nxt_s.energy = ev_in.energy_det;
		nxt_s.fc_half = ev_in.false_carrier_half;
		nxt_s.rx_half = ev_in.rx_err_half;
		nxt_s.pd_meta = pd_pin_raw;
		nxt_s.pd_sync = s_ff.pd_meta;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign pd_pin_sync = s_ff.pd_sync;

endmodule

//--- phy_irq_ctrl.sv
// Interrupt and special-control register block of a single-pair PHY,
// reached over AHB-Lite.
// Assumes a single master, word transfers and zero-wait responses; event
// sources and straps arrive on hclk, the shared pin is asynchronous.
`timescale 1ns/1ps

// Operation
// - Clock-disable bit 15 set stops the 125 MHz clock output; resets 0.
// - Power-save fields act only while override bit 14 is set.
// - Power-save field 0 is normal, 1 is IEEE power-down of all blocks.
// - In IEEE power-down the PLL also powers down when bit 11 is zero.
// - Bit 10 set with PHY address zero isolates the MAC interface.
// - FIFO depth field 0..3 gives 4, 5, 6, 8 nibbles; resets to 5.
// - Polarity 0 idles low, asserts high; 1 (reset) idles high, asserts low.
// - Force bit drives the interrupt pin asserted regardless of events.
// - Global enable 1 allows event interrupts, 0 blocks them but not the force bit; resets to 1.
// - Pin-function bit 1 makes the pin an output, 0 a power-down input.
// - Latch link-quality event when quality turns bad while link is up.
// - Latch energy-detect on both edges, or rising only when configured.
// - Latch an event whenever the link status changes.
// - Latch an event when a wake-on-LAN packet arrives.
// - Latch an event when an electrostatic discharge is detected.
// - Latch an event when master/slave link training completes.
// - Latch an event when the false carrier counter reaches half full.
// - Latch an event when the receive error counter reaches half full.
// - Pending bits hold until the event register is read; read clears.
// - Low byte holds per-event enables, reset 0, gating the bit above.
// - A flag records pin assertion; reading the event register clears it.
module phy_irq_ctrl (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Event sources and strap
	input phy_irq_pkg::event_in_s ev_in,
	input wire logic [4:0] phy_addr,
	// Shared interrupt / power-down pin
	input wire logic irq_pin_i,
	output logic irq_pin_o,
	output logic irq_pin_oe,
	// Controls to the rest of the PHY
	output phy_irq_pkg::power_ctrl_s pwr,
	output logic pd_request
);

	phy_irq_pkg::ctl_s s_ff;
	phy_irq_pkg::ctl_s nxt_s;
	logic [7:0] ev_pulse;
	logic pd_pin_sync;
	logic [7:0] hidx;
	logic mapped;
	logic rd_acc;
	logic wr_acc;
	logic asserted;

	// ------------------------------------------------------------------
	// Event capture and pin synchroniser
	// ------------------------------------------------------------------
	event_capture u_capture (
		.hclk(hclk),
		.hresetn(hresetn),
		.ev_in(ev_in),
		.rise_only(s_ff.rise_only),
		.pd_pin_raw(irq_pin_i),
		.ev_pulse(ev_pulse),
		.pd_pin_sync(pd_pin_sync)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Upper address bits must be zero; anything else is unmapped
	assign hidx = haddr[9:2];
	assign mapped = (haddr[31:10] == phy_irq_pkg::HADDR_HI_ZERO) &&
		((hidx == phy_irq_pkg::IDX_SPECIAL) ||
		(hidx == phy_irq_pkg::IDX_EVENT) ||
		(hidx == phy_irq_pkg::IDX_AUX));
	assign rd_acc = hsel & htrans[1] & hready & ~hwrite;
	// Non-word writes are dropped; they would split 16-bit fields
	assign wr_acc = hsel & htrans[1] & hready & hwrite & mapped &
		(hsize == phy_irq_pkg::HSIZE_WORD);

	// Asserted interrupt condition before polarity
	assign asserted = s_ff.sc[phy_irq_pkg::SC_FORCE] |
		(s_ff.sc[phy_irq_pkg::SC_GEN] &
		(|(s_ff.pend & s_ff.ev_en)));

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Writes land first so a read right behind a write sees the new value
	always_comb begin
		nxt_s = s_ff;
		// Soft reset is a one-cycle strobe
		nxt_s.sc[phy_irq_pkg::SC_SGMII_RST] = 1'b0;
		if (s_ff.wr_pend) begin
			case (s_ff.wr_idx)
				phy_irq_pkg::IDX_SPECIAL: begin
					nxt_s.sc = hwdata[15:0] & phy_irq_pkg::SPECIAL_WR_MASK;
				end
				phy_irq_pkg::IDX_EVENT: begin
					nxt_s.ev_en = hwdata[7:0];
				end
				phy_irq_pkg::IDX_AUX: begin
					nxt_s.rise_only = hwdata[phy_irq_pkg::AUX_RISE_ONLY];
				end
				default: begin
				end
			endcase
		end
		if (rd_acc) begin
			nxt_s.rdata = 16'h0000;
			if (mapped) begin
				case (hidx)
					phy_irq_pkg::IDX_SPECIAL: begin
						nxt_s.rdata = nxt_s.sc;
					end
					phy_irq_pkg::IDX_EVENT: begin
						nxt_s.rdata = {s_ff.pend, nxt_s.ev_en};
						nxt_s.pend = 8'h00;
						nxt_s.pin_flag = 1'b0;
					end
					phy_irq_pkg::IDX_AUX: begin
						nxt_s.rdata[phy_irq_pkg::AUX_RISE_ONLY] =
							nxt_s.rise_only;
						nxt_s.rdata[phy_irq_pkg::AUX_PIN_FLAG] = s_ff.pin_flag;
						nxt_s.rdata[phy_irq_pkg::AUX_PD_PIN] = pd_pin_sync;
						nxt_s.rdata[phy_irq_pkg::AUX_IRQ_ACTIVE] = asserted;
					end
					default: begin
					end
				endcase
			end
		end
		// New events beat a clearing read in the same cycle
		nxt_s.pend = nxt_s.pend | ev_pulse;
		// Flag only when the pin really drives the asserted level
		if (asserted && s_ff.sc[phy_irq_pkg::SC_PIN_OUT]) begin
			nxt_s.pin_flag = 1'b1;
		end
		nxt_s.irq_level = asserted ^ s_ff.sc[phy_irq_pkg::SC_INT_POL];
		// Write data follows one cycle later, so keep the target
		nxt_s.wr_pend = wr_acc;
		nxt_s.wr_idx = hidx;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
			s_ff.sc <= phy_irq_pkg::SPECIAL_RESET;
			s_ff.ev_en <= phy_irq_pkg::EVENT_EN_RESET;
			// Idle level of the reset polarity
			s_ff.irq_level <=
				phy_irq_pkg::SPECIAL_RESET[phy_irq_pkg::SC_INT_POL];
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Zero-wait slave; reads answer from the register captured above
	assign hrdata = {16'h0000, s_ff.rdata};
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Pin level from a flop; driven only in output mode
	assign irq_pin_o = s_ff.irq_level;
	assign irq_pin_oe = s_ff.sc[phy_irq_pkg::SC_PIN_OUT];
	assign pd_request = ~s_ff.sc[phy_irq_pkg::SC_PIN_OUT] &
		pd_pin_sync;

	// Power and interface controls
	always_comb begin
		pwr.clk_out_en = ~s_ff.sc[phy_irq_pkg::SC_CLK_DIS];
		pwr.ps_down = s_ff.sc[phy_irq_pkg::SC_PS_OVR] &&
			(s_ff.sc[phy_irq_pkg::SC_PS_HI:phy_irq_pkg::SC_PS_LO] ==
			phy_irq_pkg::PS_IEEE);
		pwr.pll_down = pwr.ps_down &
			~s_ff.sc[phy_irq_pkg::SC_SGMII_RST];
		pwr.isolate_mac = s_ff.sc[phy_irq_pkg::SC_ISO_ZERO] &&
			(phy_addr == phy_irq_pkg::PHY_ADDR_ZERO);
		pwr.sgmii_reset = s_ff.sc[phy_irq_pkg::SC_SGMII_RST];
		case (s_ff.sc[phy_irq_pkg::SC_FIFO_HI:phy_irq_pkg::SC_FIFO_LO])
			2'h0: pwr.fifo_depth = phy_irq_pkg::FIFO_DEPTH_0;
			2'h1: pwr.fifo_depth = phy_irq_pkg::FIFO_DEPTH_1;
			2'h2: pwr.fifo_depth = phy_irq_pkg::FIFO_DEPTH_2;
			default: pwr.fifo_depth = phy_irq_pkg::FIFO_DEPTH_3;
		endcase
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic wr_sc;
	logic wr_ev;
	logic rd_ev;
	assign wr_sc = s_ff.wr_pend && (s_ff.wr_idx == phy_irq_pkg::IDX_SPECIAL);
	assign wr_ev = s_ff.wr_pend && (s_ff.wr_idx == phy_irq_pkg::IDX_EVENT);
	assign rd_ev = rd_acc && mapped && (hidx == phy_irq_pkg::IDX_EVENT);

	a_clk_disable: assert property (
		wr_sc |=> (pwr.clk_out_en == !$past(hwdata[15])))
		else $error("clock output enable does not follow bit 15");

	a_ps_override: assert property (
		!s_ff.sc[phy_irq_pkg::SC_PS_OVR] |-> !pwr.ps_down && !pwr.pll_down)
		else $error("power-down without override bit");

	a_ieee_mode: assert property (
		wr_sc && hwdata[14] && (hwdata[13:12] == 2'h1)
		|=> pwr.ps_down)
		else $error("IEEE power-down not entered after write");

	a_pll_down: assert property (
		wr_sc && hwdata[14] && (hwdata[13:12] == 2'h1) && !hwdata[11]
		|=> pwr.pll_down && pwr.ps_down)
		else $error("PLL not powered down in IEEE mode");

	a_isolate_addr: assert property (
		pwr.isolate_mac |-> (phy_addr == 5'h00) &&
		s_ff.sc[phy_irq_pkg::SC_ISO_ZERO])
		else $error("isolation outside address zero");

	a_fifo_depth: assert property (
		wr_sc && (hwdata[9:8] == 2'h3) |=> (pwr.fifo_depth == 4'h8))
		else $error("FIFO depth code 3 is not 8 nibbles");

	a_pin_level: assert property (
		!s_ff.sc[phy_irq_pkg::SC_FORCE] && !asserted && $stable(s_ff.sc)
		|=> (irq_pin_o == $past(s_ff.sc[phy_irq_pkg::SC_INT_POL])))
		else $error("idle pin level does not match polarity");

	a_force_pin: assert property (
		s_ff.sc[phy_irq_pkg::SC_FORCE] |=>
		(irq_pin_o == !$past(s_ff.sc[phy_irq_pkg::SC_INT_POL])))
		else $error("forced interrupt not at asserted level");

	a_gen_block: assert property (
		!s_ff.sc[phy_irq_pkg::SC_GEN] && !s_ff.sc[phy_irq_pkg::SC_FORCE]
		|-> !asserted)
		else $error("interrupt asserted while globally disabled");

	a_pin_mode: assert property (
		wr_sc && !hwdata[0] |=> !irq_pin_oe ##1 !irq_pin_oe || wr_sc)
		else $error("pin still driven in input mode");

	a_event_latch: assert property (
		(ev_pulse != 8'h00) |=> ((s_ff.pend & $past(ev_pulse)) ==
		$past(ev_pulse)))
		else $error("event pulse lost");

	a_read_clear: assert property (
		rd_ev && (ev_pulse == 8'h00) |=> (s_ff.pend == 8'h00) &&
		(hrdata[15:8] == $past(s_ff.pend)))
		else $error("event read did not return and clear pending bits");

	a_enable_write: assert property (
		wr_ev |=> (s_ff.ev_en == $past(hwdata[7:0])))
		else $error("event enables not written");

	a_pin_flag: assert property (
		asserted && irq_pin_oe |=> s_ff.pin_flag ##1
		(s_ff.pin_flag || $past(rd_ev)))
		else $error("pin assertion flag not held until read");

	// Link-quality, energy and link pulses need their cause; wake-on-LAN, discharge and training must latch; pin follows the condition
	a_lq_event: assert property (
		ev_pulse[phy_irq_pkg::EV_LINK_QUAL] |->
		ev_in.link_up && !ev_in.link_qual_good)
		else $error("link-quality event without bad quality on link");

	a_energy_edge: assert property (
		ev_pulse[phy_irq_pkg::EV_ENERGY] && s_ff.rise_only |->
		ev_in.energy_det)
		else $error("energy falling edge latched in rising-only mode");

	a_link_change: assert property (
		ev_pulse[phy_irq_pkg::EV_LINK] |->
		(ev_in.link_up != $past(ev_in.link_up)))
		else $error("link event without a change of link status");

	a_wol_latch: assert property (
		ev_in.wol_rx |=> s_ff.pend[phy_irq_pkg::EV_WOL])
		else $error("wake-on-LAN event not latched");

	a_esd_latch: assert property (
		ev_in.esd_det |=> s_ff.pend[phy_irq_pkg::EV_ESD])
		else $error("discharge event not latched");

	a_train_latch: assert property (
		ev_in.training_complete_event |=>
		s_ff.pend[phy_irq_pkg::EV_TRAIN])
		else $error("training-complete event not latched");

	a_pend_hold: assert property (
		!rd_ev |=>
		((s_ff.pend & $past(s_ff.pend)) == $past(s_ff.pend)))
		else $error("pending bit dropped without an event read");

	a_fifo_shallow: assert property (
		wr_sc && (hwdata[9:8] == 2'h0) |=> (pwr.fifo_depth == 4'h4))
		else $error("FIFO depth code 0 is not 4 nibbles");

	a_irq_level: assert property (
		asserted |=>
		(irq_pin_o != $past(s_ff.sc[phy_irq_pkg::SC_INT_POL])))
		else $error("asserted condition not shown on the pin");

	a_pd_input: assert property (
		pd_request |-> !irq_pin_oe)
		else $error("power-down request while the pin is an output");

	a_sgmii_strobe: assert property (
		pwr.sgmii_reset && !wr_sc |=> !pwr.sgmii_reset)
		else $error("soft reset strobe longer than one cycle");

	c_event_irq: cover property (
		ev_pulse[phy_irq_pkg::EV_WOL] && s_ff.ev_en[phy_irq_pkg::EV_WOL]
		##2 irq_pin_o != s_ff.sc[phy_irq_pkg::SC_INT_POL]);
	c_read_clear: cover property (rd_ev && (s_ff.pend != 8'h00));
	c_set_wins: cover property (rd_ev && (ev_pulse != 8'h00));
	c_input_mode: cover property (pd_request);
	c_force_pin: cover property (s_ff.sc[phy_irq_pkg::SC_FORCE] &&
		irq_pin_oe);

endmodule

//--- phy_host_model.sv
// AHB-Lite master standing in for the station management host.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps

module phy_host_model (
	// Clock
	input wire logic hclk,
	// AHB-Lite master side
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = phy_irq_pkg::HSIZE_WORD;
		hwdata = 32'h0;
	end

	// One single word transfer; no wait count assumed, bench timeout rules
	task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		// Start on a clock edge so every change lands right after it
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= phy_irq_pkg::HSIZE_WORD;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
		// Released data lines show a changed pattern, never stale data
		hwdata <= ~d;
	endtask
endmodule

//--- phy_interrupt_and_special_control_test.sv
// Self-checking bench for the PHY interrupt and special-control block.
// Assumes the host model drives the bus; the shared pin is resolved here.
`timescale 1ns/1ps

module phy_interrupt_and_special_control_test;
	// ------------------------------------------------------------------
	// Signals and map
	// ------------------------------------------------------------------
	localparam logic [31:0] A_SC = {22'h0, phy_irq_pkg::IDX_SPECIAL, 2'h0};
	localparam logic [31:0] A_EV = {22'h0, phy_irq_pkg::IDX_EVENT, 2'h0};
	localparam logic [31:0] A_AUX = {22'h0, phy_irq_pkg::IDX_AUX, 2'h0};
	localparam logic [31:0] A_NONE = 32'h00000084;
	// Event source steps and the pending byte each must leave
	localparam logic [7:0] EV_V [11] = '{8'hc0, 8'h40, 8'hc0, 8'he0, 8'hc0,
		8'hd0, 8'hc8, 8'hc4, 8'hc2, 8'hc1, 8'h80};
	localparam logic [7:0] EV_P [11] = '{8'h20, 8'h80, 8'h00, 8'h40, 8'h40,
		8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h20};
	localparam logic [3:0] DEPTH [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] phy_addr;
	logic irq_pin_o, irq_pin_oe, irq_wire, pd_drive, pd_request;
	phy_irq_pkg::event_in_s ev_in;
	phy_irq_pkg::power_ctrl_s pwr;
	int error_cnt, n_tests;

	// Pin level from whoever drives it
	assign irq_wire = irq_pin_oe ? irq_pin_o : pd_drive;

	phy_irq_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ev_in(ev_in),
		.phy_addr(phy_addr), .irq_pin_i(irq_wire), .irq_pin_o(irq_pin_o),
		.irq_pin_oe(irq_pin_oe), .pwr(pwr), .pd_request(pd_request));

	phy_host_model u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task check(input string name, input logic [31:0] got,
		input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task give_verdict;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_host.xfer(1'b1, a, d, q);
	endtask

	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		u_host.xfer(1'b0, a, 32'h0, q);
		check("hrdata", q, exp);
		check("hresp", hresp, 1'b0);
		check("hreadyout", hreadyout, 1'b1);
	endtask

	// Let the latest register update reach the pin
	task settle;
		@(posedge hclk);
		#1;
	endtask

	// One-cycle pulse on the pulse sources, levels stay at the new value
	task pulse(input logic [7:0] v);
		@(posedge hclk);
		ev_in <= phy_irq_pkg::event_in_s'(v);
		@(posedge hclk);
		ev_in <= phy_irq_pkg::event_in_s'(v & 8'he0);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_reset;
		#1;
		check("clk_out_en", pwr.clk_out_en, 1'b1);
		check("ps_down", pwr.ps_down, 1'b0);
		check("fifo_depth", pwr.fifo_depth, 4'h5);
		check("irq_pin_oe", irq_pin_oe, 1'b1);
		check("irq_pin_o", irq_pin_o, 1'b1);
		rd_chk(A_SC, 32'h0000010b);
		rd_chk(A_EV, 32'h00000000);
		rd_chk(A_AUX, 32'h00000004);
	endtask

	// Unmapped write is dropped and reads back zero
	task t_unmapped;
		wr(A_NONE, 32'h0000ffff);
		rd_chk(A_NONE, 32'h00000000);
		rd_chk(A_SC, 32'h0000010b);
	endtask

	task t_power;
		wr(A_SC, 32'h0000d10b);
		settle;
		check("clk_out_en", pwr.clk_out_en, 1'b0);
		check("ps_down", pwr.ps_down, 1'b1);
		check("pll_down", pwr.pll_down, 1'b1);
		// Soft reset bit is a one-cycle strobe that spares the PLL
		wr(A_SC, 32'h00005b0b);
		#1;
		check("sgmii_reset", pwr.sgmii_reset, 1'b1);
		check("pll_down", pwr.pll_down, 1'b0);
		settle;
		check("sgmii_reset", pwr.sgmii_reset, 1'b0);
		check("pll_down", pwr.pll_down, 1'b1);
		rd_chk(A_SC, 32'h0000530b);
		wr(A_SC, 32'h0000910b);
		settle;
		check("ps_down", pwr.ps_down, 1'b0);
		wr(A_SC, 32'h0000610b);
		settle;
		check("ps_down", pwr.ps_down, 1'b0);
		wr(A_SC, 32'h0000050b);
		settle;
		check("isolate_mac", pwr.isolate_mac, 1'b1);
		@(posedge hclk);
		phy_addr <= 5'h01;
		settle;
		check("isolate_mac", pwr.isolate_mac, 1'b0);
		@(posedge hclk);
		phy_addr <= 5'h00;
		for (int i = 0; i < 4; i++) begin
			wr(A_SC, {22'h0, i[1:0], 8'h0b});
			settle;
			check("fifo_depth", pwr.fifo_depth, DEPTH[i]);
			rd_chk(A_SC, {22'h0, i[1:0], 8'h0b});
		end
		wr(A_SC, 32'h0000010b);
	endtask

	// Each source latches its bit; the read clears it for the next step
	task t_events;
		for (int i = 0; i < 11; i++) begin
			pulse(EV_V[i]);
			rd_chk(A_EV, {16'h0, EV_P[i], 8'h00});
		end
		wr(A_AUX, 32'h00000001);
		pulse(8'ha0);
		rd_chk(A_EV, 32'h00004000);
		pulse(8'h80);
		rd_chk(A_EV, 32'h00000000);
		wr(A_AUX, 32'h00000000);
	endtask

	task t_irq;
		wr(A_EV, 32'h00000010);
		pulse(8'h90);
		settle;
		check("irq_pin_o", irq_pin_o, 1'b0);
		// Synced pin needs two edges to show the low level
		@(posedge hclk);
		rd_chk(A_AUX, 32'h0000000a);
		rd_chk(A_EV, 32'h00001010);
		#1;
		check("irq_pin_o", irq_pin_o, 1'b1);
		rd_chk(A_EV, 32'h00000010);
		rd_chk(A_AUX, 32'h00000004);
		pulse(8'h88);
		settle;
		check("irq_pin_o", irq_pin_o, 1'b1);
		rd_chk(A_EV, 32'h00000810);
		wr(A_SC, 32'h00000109);
		pulse(8'h90);
		settle;
		check("irq_pin_o", irq_pin_o, 1'b1);
		rd_chk(A_EV, 32'h00001010);
		wr(A_SC, 32'h0000010d);
		settle;
		check("irq_pin_o", irq_pin_o, 1'b0);
		wr(A_SC, 32'h00000105);
		settle;
		check("irq_pin_o", irq_pin_o, 1'b1);
		wr(A_SC, 32'h00000101);
		settle;
		check("irq_pin_o", irq_pin_o, 1'b0);
		// Input mode: the pin becomes a power-down request
		wr(A_SC, 32'h00000100);
		settle;
		check("irq_pin_oe", irq_pin_oe, 1'b0);
		@(posedge hclk);
		pd_drive <= 1'b1;
		repeat (3) @(posedge hclk);
		#1;
		check("pd_request", pd_request, 1'b1);
		@(posedge hclk);
		pd_drive <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
		check("pd_request", pd_request, 1'b0);
		wr(A_SC, 32'h0000010b);
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Whole run is well under 2000 cycles; allow five times that
	initial begin
		#100000;
		error_cnt++;
		give_verdict;
	end

	initial begin
		error_cnt = 0;
		n_tests = 0;
		hresetn = 1'b0;
		ev_in = phy_irq_pkg::event_in_s'(8'h80);
		phy_addr = 5'h00;
		pd_drive = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_unmapped;
		t_power;
		t_events;
		t_irq;
		give_verdict;
	end
endmodule
